//--- verilog/tla_defs.vh
/*
 * constants for the transmit loss and all-ones alarm unit: field positions,
 * reset values and timing counts.
 * assumes the including file runs on one 125 MHz clock.
 */
`ifndef TLA_DEFS_VH
`define TLA_DEFS_VH
// zero-count thresholds and block lengths
`define TLA_E1_BLOCK_BITS 14'd512
`define TLA_E1_MIN_ZEROS 4'd3
`define TLA_T1_BLOCK_BITS 14'd8192
`define TLA_T1_MIN_ZEROS 4'd9
// field positions of the alarm generation controls
`define TLA_GEN_TX_LINE 0
`define TLA_GEN_TX_SYS 1
`define TLA_GEN_RX_LINE 2
`define TLA_GEN_RX_SYS 3
`define TLA_GEN_FORCE 4
// status bit positions
`define TLA_BIT_TXLOSS 2
`define TLA_BIT_LINE_AIS 6
`define TLA_BIT_SYS_AIS 7
// loss period choices in line bit intervals, selected by the two-bit period field
`define TLA_PERIOD_0 12'd32
`define TLA_PERIOD_1 12'd64
`define TLA_PERIOD_2 12'd128
`define TLA_PERIOD_3 12'd256
// reset values
`define TLA_RST_STATUS 1'b0
`define TLA_RST_LOW_CNT 12'h000
`define TLA_RST_BITS 13'h0000
`define TLA_RST_ZEROS 4'h0
`endif

//--- verilog/tla_alarm_unit.v
/*
 * tla_alarm_unit: one channel of transmit loss detection, all-ones alarm
 * detection in both paths, latched interrupt status and all-ones generation.
 * assumes all inputs synchronous to ref_clk_i; line bits arrive with a one-cycle
 * valid strobe at the line rate; pulse amplitude is measured by the analog front
 * end and presented per pulse interval, and compared with the threshold here.
 */
`default_nettype none
`include "tla_defs.vh"

module tla_alarm_unit (
	input wire ref_clk_i,
	input wire rst_i,
	input wire e1_mode_i,
	input wire alarm_criteria_select_i,
	input wire [1:0] tx_amplitude_threshold_i,
	input wire [1:0] tx_loss_period_select_i,
	input wire tx_bit_tick_i,
	input wire [1:0] tx_pulse_level_i,
	input wire tx_driver_enable_i,
	input wire tx_loss_edge_select_i,
	input wire alarm_edge_select_i,
	input wire tx_loss_irq_mask_i,
	input wire line_alarm_irq_mask_i,
	input wire system_alarm_irq_mask_i,
	input wire tx_loss_irq_clear_i,
	input wire line_alarm_irq_clear_i,
	input wire system_alarm_irq_clear_i,
	input wire rx_bit_tick_i,
	input wire rx_bit_i,
	input wire sys_bit_tick_i,
	input wire sys_bit_i,
	input wire rx_line_signal_loss_i,
	input wire system_side_signal_loss_i,
	input wire sys_dual_rail_i,
	input wire [4:0] alarm_gen_i,
	input wire rx_pattern_active_i,
	input wire tx_pattern_active_i,
	input wire line_rate_ref_clock_i,
	input wire rx_data_pos_i,
	input wire rx_data_neg_i,
	input wire rx_clock_i,
	input wire tx_data_pos_i,
	input wire tx_data_neg_i,
	output reg tx_loss_status_o,
	output reg line_alarm_status_o,
	output reg system_alarm_status_o,
	output reg tx_loss_irq_status_o,
	output reg line_alarm_irq_status_o,
	output reg system_alarm_irq_status_o,
	output reg irq_o,
	output reg tx_loss_event_o,
	output reg alarm_event_o,
	output reg rx_data_pos_out_o,
	output reg rx_data_neg_out_o,
	output reg rx_clock_out_o,
	output reg tx_line_tip_o,
	output reg tx_line_ring_o
);

	// edge-selected latch: rise only, or any change
	function irq_event;
		input prev;
		input cur;
		input any_edge;
		begin
			irq_event = any_edge ? (prev ^ cur) : (~prev & cur);
		end
	endfunction

	function [11:0] loss_period;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: loss_period = `TLA_PERIOD_0;
				2'h1: loss_period = `TLA_PERIOD_1;
				2'h2: loss_period = `TLA_PERIOD_2;
				default: loss_period = `TLA_PERIOD_3;
			endcase
		end
	endfunction

	// saturating zero count: only whether the threshold is reached matters
	function [3:0] zero_step;
		input [3:0] cur;
		input bit_in;
		reg [4:0] sum;
		begin
			sum = {1'b0, cur} + {4'h0, ~bit_in};
			zero_step = (sum > {1'b0, `TLA_T1_MIN_ZEROS}) ? `TLA_T1_MIN_ZEROS : sum[3:0];
		end
	endfunction

	// alarm state at a block end; two-block mode moves only on two agreeing verdicts
	function block_verdict;
		input cur_state;
		input low;
		input prev_low;
		input two;
		begin
			if (!two || low == prev_low)
				block_verdict = low;
			else
				block_verdict = cur_state;
		end
	endfunction

	// latched status: a new event wins over a clear in the same cycle
	function irq_latch;
		input is_q;
		input clr;
		input prev;
		input cur;
		input any_edge;
		begin
			irq_latch = (is_q & ~clr) | irq_event(prev, cur, any_edge);
		end
	endfunction

	reg [11:0] low_cnt_q;
	reg [12:0] rx_bits_q;
	reg [3:0] rx_zeros_q;
	reg rx_prev_low_q;
	reg [12:0] sys_bits_q;
	reg [3:0] sys_zeros_q;
	reg sys_prev_low_q;

	wire pulse_ok = tx_pulse_level_i > tx_amplitude_threshold_i;
	// a disabled driver watches the partner's line; with both off no pulse ever arrives
	wire tx_loss_next_pulse = tx_bit_tick_i & pulse_ok;
	wire [11:0] period = loss_period(tx_loss_period_select_i);

	wire [13:0] block_len = e1_mode_i ? `TLA_E1_BLOCK_BITS : `TLA_T1_BLOCK_BITS;
	wire [13:0] block_last = block_len - 14'd1;
	wire [3:0] min_zeros = e1_mode_i ? `TLA_E1_MIN_ZEROS : `TLA_T1_MIN_ZEROS;
	wire two_blocks = e1_mode_i & ~alarm_criteria_select_i;
	// at or past the last bit: a mode change can leave a count beyond the new block
	wire rx_end = rx_bit_tick_i && ({1'b0, rx_bits_q} >= block_last);
	wire sys_end = sys_bit_tick_i && ({1'b0, sys_bits_q} >= block_last);
	wire [3:0] rx_z = zero_step(rx_zeros_q, rx_bit_i);
	wire [3:0] sys_z = zero_step(sys_zeros_q, sys_bit_i);
	wire rx_low = rx_z < min_zeros;
	wire sys_low = sys_z < min_zeros;

	reg tx_loss_d;
	reg line_ais_d;
	reg sys_ais_d;
	always @* begin
		tx_loss_d = tx_loss_status_o;
		if (tx_loss_next_pulse)
			tx_loss_d = 1'b0;
		else if (tx_bit_tick_i && low_cnt_q + 12'd1 >= period)
			tx_loss_d = 1'b1;
		line_ais_d = line_alarm_status_o;
		if (rx_end)
			line_ais_d = block_verdict(line_alarm_status_o, rx_low,
				rx_prev_low_q, two_blocks);
		sys_ais_d = system_alarm_status_o;
		if (sys_end)
			sys_ais_d = block_verdict(system_alarm_status_o, sys_low,
				sys_prev_low_q, two_blocks);
	end

	// automatic all-ones, system loss only meaningful with dual-rail input
	wire sys_loss = system_side_signal_loss_i & sys_dual_rail_i;
	wire rx_ones = (alarm_gen_i[`TLA_GEN_RX_LINE] & rx_line_signal_loss_i) |
		(alarm_gen_i[`TLA_GEN_RX_SYS] & sys_loss);
	wire tx_ones = (alarm_gen_i[`TLA_GEN_TX_LINE] & rx_line_signal_loss_i) |
		(alarm_gen_i[`TLA_GEN_TX_SYS] & sys_loss) | alarm_gen_i[`TLA_GEN_FORCE];

	reg tl_is_d;
	reg la_is_d;
	reg sa_is_d;
	always @* begin
		// set wins over a simultaneous clear
		tl_is_d = irq_latch(tx_loss_irq_status_o, tx_loss_irq_clear_i,
			tx_loss_status_o, tx_loss_d, tx_loss_edge_select_i);
		la_is_d = irq_latch(line_alarm_irq_status_o, line_alarm_irq_clear_i,
			line_alarm_status_o, line_ais_d, alarm_edge_select_i);
		sa_is_d = irq_latch(system_alarm_irq_status_o, system_alarm_irq_clear_i,
			system_alarm_status_o, sys_ais_d, alarm_edge_select_i);
	end

	// transmit loss: low intervals are counted, any valid pulse restarts the count
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			low_cnt_q <= `TLA_RST_LOW_CNT;
			tx_loss_status_o <= `TLA_RST_STATUS;
			tx_loss_event_o <= 1'b0;
		end else begin
			if (tx_loss_next_pulse)
				low_cnt_q <= `TLA_RST_LOW_CNT;
			else if (tx_bit_tick_i && low_cnt_q != 12'hFFF)
				low_cnt_q <= low_cnt_q + 12'd1;
			tx_loss_status_o <= tx_loss_d;
			tx_loss_event_o <= ~tx_loss_status_o & tx_loss_d;
		end
	end

	// receive path blocks run from reset; each block end restarts both counts
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			rx_bits_q <= `TLA_RST_BITS;
			rx_zeros_q <= `TLA_RST_ZEROS;
			rx_prev_low_q <= 1'b0;
			line_alarm_status_o <= `TLA_RST_STATUS;
		end else begin
			if (rx_bit_tick_i) begin
				rx_bits_q <= rx_end ? `TLA_RST_BITS : rx_bits_q + 13'd1;
				rx_zeros_q <= rx_end ? `TLA_RST_ZEROS : rx_z;
				if (rx_end)
					rx_prev_low_q <= rx_low;
			end
			line_alarm_status_o <= line_ais_d;
		end
	end

	// transmit path blocks, same scheme as the receive side
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			sys_bits_q <= `TLA_RST_BITS;
			sys_zeros_q <= `TLA_RST_ZEROS;
			sys_prev_low_q <= 1'b0;
			system_alarm_status_o <= `TLA_RST_STATUS;
		end else begin
			if (sys_bit_tick_i) begin
				sys_bits_q <= sys_end ? `TLA_RST_BITS : sys_bits_q + 13'd1;
				sys_zeros_q <= sys_end ? `TLA_RST_ZEROS : sys_z;
				if (sys_end)
					sys_prev_low_q <= sys_low;
			end
			system_alarm_status_o <= sys_ais_d;
		end
	end

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			tx_loss_irq_status_o <= 1'b0;
			line_alarm_irq_status_o <= 1'b0;
			system_alarm_irq_status_o <= 1'b0;
			irq_o <= 1'b0;
			alarm_event_o <= 1'b0;
		end else begin
			tx_loss_irq_status_o <= tl_is_d;
			line_alarm_irq_status_o <= la_is_d;
			system_alarm_irq_status_o <= sa_is_d;
			// built from the next-state latches so irq_o rises with its status bit
			irq_o <= (tl_is_d & ~tx_loss_irq_mask_i) |
				(la_is_d & ~line_alarm_irq_mask_i) | (sa_is_d & ~system_alarm_irq_mask_i);
			alarm_event_o <= (~line_alarm_status_o & line_ais_d) |
				(~system_alarm_status_o & sys_ais_d);
		end
	end

	// pattern generation outranks the automatic alarm
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			rx_data_pos_out_o <= 1'b0;
			rx_data_neg_out_o <= 1'b0;
			rx_clock_out_o <= 1'b0;
		end else if (rx_ones && !rx_pattern_active_i) begin
			rx_data_pos_out_o <= 1'b1;
			rx_data_neg_out_o <= 1'b1;
			rx_clock_out_o <= line_rate_ref_clock_i;
		end else begin
			rx_data_pos_out_o <= rx_data_pos_i;
			rx_data_neg_out_o <= rx_data_neg_i;
			rx_clock_out_o <= rx_clock_i;
		end
	end

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			tx_line_tip_o <= 1'b0;
			tx_line_ring_o <= 1'b0;
		end else if (tx_ones && !tx_pattern_active_i) begin
			tx_line_tip_o <= 1'b1;
			tx_line_ring_o <= 1'b1;
		end else begin
			tx_line_tip_o <= tx_data_pos_i;
			tx_line_ring_o <= tx_data_neg_i;
		end
	end

endmodule // tla_alarm_unit
`default_nettype wire

//--- tb/tla_alarm_unit_props.sv
/*
 * tla_alarm_unit_props: port-level checks of status, latched irq, events and output muxing.
 * assumes the bind below, one clock and a synchronous active-high reset.
 */
`default_nettype none
module tla_alarm_unit_props (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic tx_bit_tick_i,
	input wire logic tx_loss_irq_mask_i,
	input wire logic tx_loss_irq_clear_i,
	input wire logic [1:0] tx_pulse_level_i,
	input wire logic [1:0] tx_amplitude_threshold_i,
	input wire logic [4:0] alarm_gen_i,
	input wire logic tx_pattern_active_i,
	input wire logic rx_pattern_active_i,
	input wire logic tx_data_pos_i,
	input wire logic tx_data_neg_i,
	input wire logic rx_data_pos_i,
	input wire logic rx_line_signal_loss_i,
	input wire logic sys_dual_rail_i,
	input wire logic line_rate_ref_clock_i,
	input wire logic tx_loss_status_o,
	input wire logic tx_loss_irq_status_o,
	input wire logic irq_o,
	input wire logic tx_loss_event_o,
	input wire logic alarm_event_o,
	input wire logic line_alarm_status_o,
	input wire logic system_alarm_status_o,
	input wire logic line_alarm_irq_status_o,
	input wire logic tx_line_tip_o,
	input wire logic tx_line_ring_o,
	input wire logic rx_data_pos_out_o,
	input wire logic rx_data_neg_out_o,
	input wire logic rx_clock_out_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	AST_TX_RISE: assert property ($rose(tx_loss_status_o) |-> tx_loss_irq_status_o)
		else $error("tx loss rose without irq status");
	AST_TX_EVENT: assert property ($rose(tx_loss_status_o) |-> tx_loss_event_o)
		else $error("tx loss rose without event");
	AST_LINE_IRQ: assert property ($rose(line_alarm_status_o) |-> line_alarm_irq_status_o)
		else $error("line alarm rose without irq status");
	AST_IRQ_OUT: assert property (!$past(rst_i) && tx_loss_irq_status_o && !$past(tx_loss_irq_mask_i) |-> irq_o)
		else $error("unmasked irq status without irq");
	AST_IRQ_HOLD: assert property ($past(tx_loss_irq_status_o) && !$past(tx_loss_irq_clear_i) |-> tx_loss_irq_status_o)
		else $error("irq status dropped without clear");
	AST_TX_CLEAR: assert property (!$past(rst_i) && $past(tx_bit_tick_i && tx_pulse_level_i > tx_amplitude_threshold_i)
		|-> !tx_loss_status_o) else $error("valid pulse left tx loss set");
	AST_FORCE: assert property (!$past(rst_i) && $past(alarm_gen_i[4] && !tx_pattern_active_i)
		|-> tx_line_tip_o && tx_line_ring_o) else $error("forced ones missing");
	AST_PATTERN: assert property (!$past(rst_i) && $past(tx_pattern_active_i)
		|-> tx_line_tip_o == $past(tx_data_pos_i) && tx_line_ring_o == $past(tx_data_neg_i)) else $error("pattern lost");
	AST_RX_ONES: assert property (!$past(rst_i) && $past(alarm_gen_i[2] && rx_line_signal_loss_i && !rx_pattern_active_i)
		|-> rx_data_pos_out_o && rx_data_neg_out_o && rx_clock_out_o == $past(line_rate_ref_clock_i))
		else $error("rx ones or clock missing");
	AST_DUAL_RAIL: assert property (!$past(rst_i) && $past(!sys_dual_rail_i && !rx_line_signal_loss_i && !rx_pattern_active_i)
		|-> rx_data_pos_out_o == $past(rx_data_pos_i)) else $error("system loss honoured without dual rail");
	AST_AIS_EVENT: assert property ($rose(line_alarm_status_o) || $rose(system_alarm_status_o) |-> alarm_event_o)
		else $error("alarm without event");
	cover property ($rose(tx_loss_status_o));
	cover property ($rose(line_alarm_status_o));
	cover property ($rose(system_alarm_status_o));
endmodule // tla_alarm_unit_props
bind tla_alarm_unit tla_alarm_unit_props i_tla_alarm_unit_props (.*);
`default_nettype wire

//--- tb/tla_line_model.sv
/*
 * tla_line_model: shared transmit line of two paired channels, as sensed by this one.
 * assumes the partner channel stays in high impedance; updates just after the rising edge.
 */
`default_nettype none
module tla_line_model (
	input wire logic ref_clk_i,
	input wire logic drive_i,
	input wire logic fail_i,
	output var logic tick_o = 1'b0,
	output var logic [1:0] level_o = 2'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	// high impedance or a failed driver leaves no amplitude on the line
	always @(posedge ref_clk_i) begin
		tick_o <= ~tick_o;
		level_o <= (drive_i && !fail_i) ? 2'h3 : 2'h0;
	end
endmodule // tla_line_model
`default_nettype wire

//--- tb/testbench.sv
/*
 * testbench: self-checking bench for tla_alarm_unit with a shared-line model.
 * assumes a 125 MHz clock; inputs change on the falling edge.
 */
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 0, rst_i = 1, e1_mode_i = 0, alarm_criteria_select_i = 0, tx_driver_enable_i = 1, fail = 0;
	logic tx_loss_edge_select_i = 1, alarm_edge_select_i = 0, tx_loss_irq_mask_i = 0, line_alarm_irq_mask_i = 0;
	logic system_alarm_irq_mask_i = 0, tx_loss_irq_clear_i = 0, line_alarm_irq_clear_i = 0, system_alarm_irq_clear_i = 0;
	logic rx_bit_tick_i = 0, rx_bit_i = 0, sys_bit_tick_i = 0, sys_bit_i = 0, rx_line_signal_loss_i = 0;
	logic system_side_signal_loss_i = 0, sys_dual_rail_i = 1, rx_pattern_active_i = 0, tx_pattern_active_i = 0;
	logic line_rate_ref_clock_i = 0, rx_data_pos_i = 0, rx_data_neg_i = 0, rx_clock_i = 0, tx_data_pos_i = 0, tx_data_neg_i = 0;
	logic [1:0] tx_amplitude_threshold_i = 2'h1, tx_loss_period_select_i = 2'h0, tx_pulse_level_i;
	logic [4:0] alarm_gen_i = 5'h00;
	logic tx_bit_tick_i, tx_loss_status_o, line_alarm_status_o, system_alarm_status_o, tx_loss_irq_status_o;
	logic line_alarm_irq_status_o, system_alarm_irq_status_o, irq_o, tx_loss_event_o, alarm_event_o;
	logic rx_data_pos_out_o, rx_data_neg_out_o, rx_clock_out_o, tx_line_tip_o, tx_line_ring_o;
	int fails = 0;
	int n_compared = 0;
	tla_alarm_unit i_tla_alarm_unit (.*);
	tla_line_model i_tla_line_model (.ref_clk_i, .drive_i(tx_driver_enable_i), .fail_i(fail), .tick_o(tx_bit_tick_i),
		.level_o(tx_pulse_level_i));
	always #4 ref_clk_i = ~ref_clk_i;
	always @(negedge ref_clk_i) line_rate_ref_clock_i <= ~line_rate_ref_clock_i;
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// counts transmit pulse intervals, then lets the status edge land
	task automatic ticks(input int n);
		int k;
		repeat (n) begin
			k = 0;
			do begin @(posedge ref_clk_i); k++; end while (!tx_bit_tick_i && k < 9);
			if (k >= 9) begin fails++; conclude(); end
		end
		@(negedge ref_clk_i);
	endtask
	task automatic pulse_clear;
		{tx_loss_irq_clear_i, line_alarm_irq_clear_i, system_alarm_irq_clear_i} = 3'h7;
		@(negedge ref_clk_i);
		{tx_loss_irq_clear_i, line_alarm_irq_clear_i, system_alarm_irq_clear_i} = 3'h0;
		@(negedge ref_clk_i);
	endtask
	task automatic t_txloss;
		for (int p = 0; p < 4; p++) begin
			tx_loss_period_select_i = p[1:0];
			fail = 1;
			@(posedge ref_clk_i);
			ticks((32 << p) - 1);
			`CHK(tx_loss_status_o, 1'b0)
			ticks(1);
			`CHK(tx_loss_status_o, 1'b1)
			fail = 0;
			@(posedge ref_clk_i);
			ticks(1);
			`CHK(tx_loss_status_o, 1'b0)
		end
		`CHK({tx_loss_irq_status_o, irq_o}, 2'h3)
		tx_loss_irq_mask_i = 1;
		@(negedge ref_clk_i);
		@(negedge ref_clk_i);
		`CHK(irq_o, 1'b0)
		pulse_clear();
		`CHK(tx_loss_irq_status_o, 1'b0)
		// both drivers in high impedance: nothing on the shared line
		tx_loss_period_select_i = 2'h0;
		tx_driver_enable_i = 0;
		@(posedge ref_clk_i);
		ticks(32);
		`CHK({tx_loss_status_o, tx_loss_irq_status_o}, 2'h3)
		tx_driver_enable_i = 1;
		@(posedge ref_clk_i);
		ticks(1);
		`CHK(tx_loss_status_o, 1'b0)
		fail = 0;
	endtask
	task automatic feed(input int n, input logic b);
		{rx_bit_tick_i, sys_bit_tick_i, rx_bit_i, sys_bit_i} = {2'h3, b, b};
		repeat (n) @(negedge ref_clk_i);
		{rx_bit_tick_i, sys_bit_tick_i} = 2'h0;
		repeat (2) @(negedge ref_clk_i);
	endtask
	task automatic t_ais;
		for (int m = 0; m < 3; m++) begin
			{e1_mode_i, alarm_criteria_select_i} = {m < 2, m[0]};
			feed(m < 2 ? 1600 : 17000, 1'b1);
			`CHK({line_alarm_status_o, system_alarm_status_o}, 2'h3)
			`CHK({line_alarm_irq_status_o, system_alarm_irq_status_o}, 2'h3)
			pulse_clear();
			feed(m < 2 ? 1600 : 17000, 1'b0);
			`CHK({line_alarm_status_o, system_alarm_status_o}, 2'h0)
			`CHK({line_alarm_irq_status_o, system_alarm_irq_status_o}, 2'h0)
		end
	endtask
	task automatic t_gen;
		{rx_line_signal_loss_i, system_side_signal_loss_i} = 2'h3;
		for (int i = 0; i < 5; i++) begin
			alarm_gen_i = 5'h01 << i;
			repeat (2) @(negedge ref_clk_i);
			`CHK({tx_line_tip_o, tx_line_ring_o}, (i < 2 || i == 4) ? 2'h3 : 2'h0)
			`CHK({rx_data_pos_out_o, rx_data_neg_out_o}, (i == 2 || i == 3) ? 2'h3 : 2'h0)
		end
		{alarm_gen_i, sys_dual_rail_i, rx_line_signal_loss_i} = {5'h08, 2'h0};
		repeat (2) @(negedge ref_clk_i);
		`CHK({rx_data_pos_out_o, rx_data_neg_out_o}, 2'h0)
		{alarm_gen_i, sys_dual_rail_i, rx_line_signal_loss_i, rx_pattern_active_i, tx_pattern_active_i} = 9'h1FF;
		repeat (2) @(negedge ref_clk_i);
		`CHK({tx_line_tip_o, tx_line_ring_o, rx_data_pos_out_o, rx_data_neg_out_o}, 4'h0)
	endtask
	initial begin
		repeat (20) @(negedge ref_clk_i);
		rst_i = 0;
		t_txloss();
		t_ais();
		t_gen();
		conclude();
	end
endmodule // testbench
`default_nettype wire
